// ---- logic/nfta_consts.vh ----
`ifndef NFTA_CONSTS_VH
`define NFTA_CONSTS_VH

// Register byte offsets
`define NFTA_OFS_OPTIONS 12'h10c
`define NFTA_OFS_TIMING_A 12'h110
`define NFTA_OFS_TIMING_B 12'h114

// Options register fields
`define NFTA_VALID_PAGE_HI 25
`define NFTA_VALID_PAGE_LO 16
`define NFTA_DLL_CLK_BIT 15
`define NFTA_EXT_VREF_BIT 14
`define NFTA_STROBE_C_BIT 13
`define NFTA_READ_C_BIT 12
`define NFTA_VALID_PAGE_RST 10'h0ff
`define NFTA_DLL_CLK_RST 1'h1
`define NFTA_EXT_VREF_RST 1'h0
`define NFTA_STROBE_C_RST 1'h0
`define NFTA_READ_C_RST 1'h0

// Timing register A fields
`define NFTA_WH_HI 27
`define NFTA_WH_LO 24
`define NFTA_WP_HI 20
`define NFTA_WP_LO 16
`define NFTA_RH_HI 11
`define NFTA_RH_LO 8
`define NFTA_RS_HI 4
`define NFTA_RS_LO 0
`define NFTA_WH_RST 4'hf
`define NFTA_WP_RST 5'h0f
`define NFTA_RH_RST 4'hf
`define NFTA_RS_RST 5'h0f

// Timing register B fields
`define NFTA_RLAT_HI 21
`define NFTA_RLAT_LO 16
`define NFTA_BSY_HI 14
`define NFTA_BSY_LO 8
`define NFTA_T1_HI 6
`define NFTA_T1_LO 0
`define NFTA_RLAT_RST 6'h00
`define NFTA_BSY_RST 7'h7f
`define NFTA_T1_RST 7'h7f

// Phase codes for the pulse timer
`define NFTA_PH_WRITE_HIGH 3'h0
`define NFTA_PH_WRITE_PULSE 3'h1
`define NFTA_PH_READ_HIGH 3'h2
`define NFTA_PH_READ_STROBE 3'h3
`define NFTA_PH_READ_LATCH 3'h4
`define NFTA_PH_BUSY_WAIT 3'h5
`define NFTA_PH_SETUP_LEAD 3'h6

`endif

// ---- logic/nfta_phase_timer.v ----
`timescale 1ns/100ps
`default_nettype none
`include "nfta_consts.vh"

module nfta_phase_timer (
    input wire clk,
    input wire sys_rst,
    input wire phase_start,
    input wire [6:0] phase_cycles,
    output reg phase_busy,
    output reg phase_done
);

    reg [6:0] count_reg;
    wire [6:0] load_val;

    // A zero count still holds the phase for one cycle
    assign load_val = (phase_cycles == 7'h00) ? 7'h01 : phase_cycles;

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            count_reg <= 7'h00;
            phase_busy <= 1'b0;
            phase_done <= 1'b0;
        end
        else
        begin
            phase_done <= 1'b0;
            if (phase_start && !phase_busy)
            begin
                count_reg <= load_val;
                phase_busy <= 1'b1;
            end
            else if (phase_busy)
            begin
                if (count_reg == 7'h01)
                begin
                    phase_busy <= 1'b0;
                    phase_done <= 1'b1;
                    count_reg <= 7'h00;
                end
                else
                begin
                    count_reg <= count_reg - 7'h01;
                end
            end
        end
    end

endmodule // nfta_phase_timer

`default_nettype wire

// ---- logic/nfta_config.v ----
// What this block does
// - Ten-bit valid page count, default 0x0ff
// - Bit 15 gates DLL clock, resets 1
// - Bit 14 selects external reference, resets 0
// - Bit 13 enables complementary data strobe
// - Bit 12 enables complementary read enable
// - Pulses counted in memory clock cycles
// - Sequencer never alters settings mid-command
// - Timing A fields reset to 0xf
// - Timing B: latch 0, busy/setup 0x7f
//
// Our own choice: the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
`include "nfta_consts.vh"

module nfta_config (
    input wire clk,
    input wire sys_rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire cmd_active,
    input wire phase_start,
    input wire [2:0] phase_sel,
    output wire phase_busy,
    output wire phase_done,
    output reg [9:0] valid_page_count,
    output reg dll_clk_out_en,
    output reg ext_vref_sel,
    output reg strobe_complement_enable,
    output reg read_enable_complement_enable,
    output reg [3:0] write_high_cycles,
    output reg [4:0] write_pulse_cycles,
    output reg [3:0] read_high_cycles,
    output reg [4:0] read_strobe_cycles,
    output reg [5:0] read_latch_cycles,
    output reg [6:0] busy_wait_cycles,
    output reg [6:0] setup_lead_cycles
);

    reg [9:0] valid_page_reg;
    reg dll_clk_reg;
    reg ext_vref_reg;
    reg strobe_c_reg;
    reg read_c_reg;
    reg [3:0] wh_reg;
    reg [4:0] wp_reg;
    reg [3:0] rh_reg;
    reg [4:0] rs_reg;
    reg [5:0] rlat_reg;
    reg [6:0] bsy_reg;
    reg [6:0] t1_reg;
    reg ack_reg;
    reg [31:0] rd_next;
    reg [6:0] phase_cycles_next;
    wire req;
    wire wr;
    wire [31:0] wmask;
    wire [31:0] wdat_opt;
    wire [31:0] wdat_ta;
    wire [31:0] wdat_tb;
    wire [31:0] opt_word;
    wire [31:0] ta_word;
    wire [31:0] tb_word;

    function [31:0] nfta_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [31:0] mask;
        begin
            nfta_merge = (old_val & ~mask) | (new_val & mask);
        end
    endfunction

    assign req = wb_cyc_i & wb_stb_i;
    assign wr = req & wb_we_i & ~ack_reg;
    assign wb_ack_o = ack_reg;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_lane
            assign wmask[gi*8+7:gi*8] = {8{wb_sel_i[gi]}};
        end
    endgenerate

    // Reserved positions are zero in every packed word
    assign opt_word = {6'h00, valid_page_reg, dll_clk_reg, ext_vref_reg,
                       strobe_c_reg, read_c_reg, 12'h000};
    assign ta_word = {4'h0, wh_reg, 3'h0, wp_reg, 4'h0, rh_reg, 3'h0, rs_reg};
    assign tb_word = {10'h000, rlat_reg, 1'b0, bsy_reg, 1'b0, t1_reg};

    assign wdat_opt = nfta_merge(opt_word, wb_dat_i, wmask);
    assign wdat_ta = nfta_merge(ta_word, wb_dat_i, wmask);
    assign wdat_tb = nfta_merge(tb_word, wb_dat_i, wmask);

    // Software writes: only data bits of each field are stored
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            valid_page_reg <= `NFTA_VALID_PAGE_RST;
            dll_clk_reg <= `NFTA_DLL_CLK_RST;
            ext_vref_reg <= `NFTA_EXT_VREF_RST;
            strobe_c_reg <= `NFTA_STROBE_C_RST;
            read_c_reg <= `NFTA_READ_C_RST;
            wh_reg <= `NFTA_WH_RST;
            wp_reg <= `NFTA_WP_RST;
            rh_reg <= `NFTA_RH_RST;
            rs_reg <= `NFTA_RS_RST;
            rlat_reg <= `NFTA_RLAT_RST;
            bsy_reg <= `NFTA_BSY_RST;
            t1_reg <= `NFTA_T1_RST;
        end
        else if (wr)
        begin
            case (wb_adr_i)
                `NFTA_OFS_OPTIONS:
                begin
                    valid_page_reg <= wdat_opt[`NFTA_VALID_PAGE_HI:`NFTA_VALID_PAGE_LO];
                    dll_clk_reg <= wdat_opt[`NFTA_DLL_CLK_BIT];
                    ext_vref_reg <= wdat_opt[`NFTA_EXT_VREF_BIT];
                    strobe_c_reg <= wdat_opt[`NFTA_STROBE_C_BIT];
                    read_c_reg <= wdat_opt[`NFTA_READ_C_BIT];
                end
                `NFTA_OFS_TIMING_A:
                begin
                    wh_reg <= wdat_ta[`NFTA_WH_HI:`NFTA_WH_LO];
                    wp_reg <= wdat_ta[`NFTA_WP_HI:`NFTA_WP_LO];
                    rh_reg <= wdat_ta[`NFTA_RH_HI:`NFTA_RH_LO];
                    rs_reg <= wdat_ta[`NFTA_RS_HI:`NFTA_RS_LO];
                end
                `NFTA_OFS_TIMING_B:
                begin
                    rlat_reg <= wdat_tb[`NFTA_RLAT_HI:`NFTA_RLAT_LO];
                    bsy_reg <= wdat_tb[`NFTA_BSY_HI:`NFTA_BSY_LO];
                    t1_reg <= wdat_tb[`NFTA_T1_HI:`NFTA_T1_LO];
                end
                default:
                begin
                    valid_page_reg <= valid_page_reg;
                end
            endcase
        end
    end

    // Settings seen by the sequencer are frozen while a command runs
    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            valid_page_count <= `NFTA_VALID_PAGE_RST;
            dll_clk_out_en <= `NFTA_DLL_CLK_RST;
            ext_vref_sel <= `NFTA_EXT_VREF_RST;
            strobe_complement_enable <= `NFTA_STROBE_C_RST;
            read_enable_complement_enable <= `NFTA_READ_C_RST;
            write_high_cycles <= `NFTA_WH_RST;
            write_pulse_cycles <= `NFTA_WP_RST;
            read_high_cycles <= `NFTA_RH_RST;
            read_strobe_cycles <= `NFTA_RS_RST;
            read_latch_cycles <= `NFTA_RLAT_RST;
            busy_wait_cycles <= `NFTA_BSY_RST;
            setup_lead_cycles <= `NFTA_T1_RST;
        end
        else if (!cmd_active)
        begin
            valid_page_count <= valid_page_reg;
            dll_clk_out_en <= dll_clk_reg;
            ext_vref_sel <= ext_vref_reg;
            strobe_complement_enable <= strobe_c_reg;
            read_enable_complement_enable <= read_c_reg;
            write_high_cycles <= wh_reg;
            write_pulse_cycles <= wp_reg;
            read_high_cycles <= rh_reg;
            read_strobe_cycles <= rs_reg;
            read_latch_cycles <= rlat_reg;
            busy_wait_cycles <= bsy_reg;
            setup_lead_cycles <= t1_reg;
        end
    end

    // Read mux; unmapped addresses read zero
    always @*
    begin
        case (wb_adr_i)
            `NFTA_OFS_OPTIONS: rd_next = opt_word;
            `NFTA_OFS_TIMING_A: rd_next = ta_word;
            `NFTA_OFS_TIMING_B: rd_next = tb_word;
            default: rd_next = 32'h0000_0000;
        endcase
    end

    always @(posedge clk)
    begin
        if (sys_rst)
        begin
            ack_reg <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_reg <= req & ~ack_reg;
            wb_dat_o <= rd_next;
        end
    end

    // Phase length comes from the frozen timing copy
    always @*
    begin
        case (phase_sel)
            `NFTA_PH_WRITE_HIGH: phase_cycles_next = {3'h0, write_high_cycles};
            `NFTA_PH_WRITE_PULSE: phase_cycles_next = {2'h0, write_pulse_cycles};
            `NFTA_PH_READ_HIGH: phase_cycles_next = {3'h0, read_high_cycles};
            `NFTA_PH_READ_STROBE: phase_cycles_next = {2'h0, read_strobe_cycles};
            `NFTA_PH_READ_LATCH: phase_cycles_next = {1'b0, read_latch_cycles};
            `NFTA_PH_BUSY_WAIT: phase_cycles_next = busy_wait_cycles;
            `NFTA_PH_SETUP_LEAD: phase_cycles_next = setup_lead_cycles;
            default: phase_cycles_next = 7'h01;
        endcase
    end

    nfta_phase_timer u_timer (
        .clk(clk),
        .sys_rst(sys_rst),
        .phase_start(phase_start),
        .phase_cycles(phase_cycles_next),
        .phase_busy(phase_busy),
        .phase_done(phase_done)
    );

endmodule // nfta_config

`default_nettype wire

// ---- dv/nfta_config_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "nfta_consts.vh"
module nfta_config_checker (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic cmd_active,
    input wire logic phase_start,
    input wire logic phase_busy,
    input wire logic phase_done,
    input wire logic [9:0] valid_page_count,
    input wire logic [6:0] busy_wait_cycles
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence s_take;
        phase_start && !phase_busy;
    endsequence
    sequence s_end;
        !phase_busy && phase_done;
    endsequence
    a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    a_phase_begins: assert property (s_take |=> phase_busy)
        else $error("phase not started");
    a_phase_bounded: assert property (s_take |=> phase_busy ##[0:127] s_end)
        else $error("phase too long");
    a_done_at_end: assert property ($fell(phase_busy) |-> phase_done)
        else $error("done missing");
    a_done_single: assert property (phase_done |=> !phase_done)
        else $error("done too long");
    a_cfg_frozen: assert property (cmd_active && $past(cmd_active) |->
        $stable(valid_page_count) && $stable(busy_wait_cycles))
        else $error("setting changed in command");
    a_rsvd_options: assert property (wb_ack_o && wb_adr_i == `NFTA_OFS_OPTIONS |->
        (wb_dat_o & 32'hfc000fff) == 32'h0)
        else $error("reserved bits set");
    a_rsvd_timing: assert property (wb_ack_o && wb_adr_i == `NFTA_OFS_TIMING_A |->
        (wb_dat_o & 32'hf0e0f0e0) == 32'h0)
        else $error("reserved bits set");
    a_rsvd_timing_b: assert property (wb_ack_o && wb_adr_i == `NFTA_OFS_TIMING_B |->
        (wb_dat_o & 32'hffc08080) == 32'h0)
        else $error("reserved bits set");
    a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
endmodule // nfta_config_checker
`default_nettype wire

// ---- dv/nfta_seq_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module nfta_seq_model (
    input wire logic clk,
    input wire logic phase_busy,
    input wire logic phase_done,
    output logic cmd_active,
    output logic phase_start,
    output logic [2:0] phase_sel
);
    initial
    begin
        cmd_active = 1'b0;
        phase_start = 1'b0;
        phase_sel = 3'h0;
    end
    // Opens a command around one phase, counts busy cycles, zero if done is missing
    task automatic run(input logic [2:0] s, output integer n);
        n = 0;
        @(posedge clk);
        {cmd_active, phase_start, phase_sel} <= {2'b11, s};
        @(posedge clk);
        phase_start <= 1'b0;
        #1;
        while (phase_busy === 1'b1 && n < 200)
        begin
            n++;
            @(posedge clk);
            #1;
        end
        if (phase_done !== 1'b1)
            n = 0;
        @(posedge clk);
        cmd_active <= 1'b0;
    endtask
endmodule // nfta_seq_model
`default_nettype wire

// ---- dv/nfta_config_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "nfta_consts.vh"
module nfta_config_tb_top;
    logic clk = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0, ack, cmd, pst, busy, done;
    logic [11:0] adr = 0;
    logic [3:0] sel = 0, s;
    logic [31:0] wdat = 0, q, rdat, d;
    logic [2:0] psel;
    logic [9:0] vpc;
    logic dll, xref, sce, rce;
    logic [3:0] wh, rh;
    logic [4:0] wp, rs;
    logic [5:0] rl;
    logic [6:0] bw, sl;
    logic [31:0] out [3], cur [3];
    logic [11:0] ofs [3] = '{`NFTA_OFS_OPTIONS, `NFTA_OFS_TIMING_A, `NFTA_OFS_TIMING_B};
    logic [31:0] msk [3] = '{32'h03fff000, 32'h0f1f0f1f, 32'h003f7f7f};
    integer err_total = 0, comparisons = 0, seed = 32'h0f37b006, n, k;
    always #12.5 clk = ~clk;
    assign out[0] = {6'h0, vpc, dll, xref, sce, rce, 12'h0};
    assign out[1] = {4'h0, wh, 3'h0, wp, 4'h0, rh, 3'h0, rs};
    assign out[2] = {10'h0, rl, 1'b0, bw, 1'b0, sl};
    nfta_config i_nfta_config (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(q),
        .wb_ack_o(ack), .cmd_active(cmd), .phase_start(pst), .phase_sel(psel),
        .phase_busy(busy), .phase_done(done), .valid_page_count(vpc), .dll_clk_out_en(dll),
        .ext_vref_sel(xref), .strobe_complement_enable(sce),
        .read_enable_complement_enable(rce), .write_high_cycles(wh), .write_pulse_cycles(wp),
        .read_high_cycles(rh), .read_strobe_cycles(rs), .read_latch_cycles(rl),
        .busy_wait_cycles(bw), .setup_lead_cycles(sl));
    nfta_seq_model i_nfta_seq_model (.clk(clk), .phase_busy(busy), .phase_done(done),
        .cmd_active(cmd), .phase_start(pst), .phase_sel(psel));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v, input logic [3:0] b);
        integer t;
        t = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, v, b};
        do
        begin
            @(posedge clk);
            #1;
        end
        while (ack !== 1'b1 && ++t < 20);
        if (ack !== 1'b1)
            err_total++;
        rdat = q;
        @(posedge clk);
        {cyc, stb} <= 2'b00;
    endtask
    function automatic logic [31:0] mrg(input logic [31:0] o, v, input logic [3:0] b, input logic [31:0] m);
        logic [31:0] e;
        e = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
        return ((v & e) | (o & ~e)) & m;
    endfunction
    function automatic integer plen(input integer p);
        logic [31:0] f;
        case (p)
            0: f = cur[1] >> 24 & 32'hf;
            1: f = cur[1] >> 16 & 32'h1f;
            2: f = cur[1] >> 8 & 32'hf;
            3: f = cur[1] & 32'h1f;
            4: f = cur[2] >> 16 & 32'h3f;
            5: f = cur[2] >> 8 & 32'h7f;
            6: f = cur[2] & 32'h7f;
            default: f = 1;
        endcase
        return (f == 0) ? 1 : f;
    endfunction
    task automatic end_sim;
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial
    begin
        #(25 * 30000);
        err_total++;
        end_sim;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        cur = '{32'h00ff8000, 32'h0f0f0f0f, 32'h00007f7f};
        for (k = 0; k < 3; k++)
        begin
            bus(1'b0, ofs[k], 32'h0, 4'hf);
            chk(rdat, cur[k]);
            chk(out[k], cur[k]);
        end
        for (int i = 0; i < 24; i++)
        begin
            k = i % 3;
            d = (i < 3) ? 32'hffffffff : (i < 6) ? 32'h0 : $random(seed);
            s = (i > 20) ? 4'h4 : 4'hf;
            bus(1'b1, ofs[k], d, s);
            cur[k] = mrg(cur[k], d, s, msk[k]);
            bus(1'b0, ofs[k], 32'h0, 4'hf);
            chk(rdat, cur[k]);
            chk(out[k], cur[k]);
        end
        bus(1'b1, 12'h118, 32'hffffffff, 4'hf);
        bus(1'b0, 12'h118, 32'h0, 4'hf);
        chk(rdat, 32'h0);
        for (int p = 0; p < 8; p++)
        begin
            i_nfta_seq_model.run(p[2:0], n);
            chk(n, plen(p));
        end
        bus(1'b1, ofs[2], 32'h00143f05, 4'hf);
        cur[2] = 32'h00143f05;
        bus(1'b1, ofs[0], 32'h00bf8000, 4'hf);
        cur[0] = 32'h00bf8000;
        d = cur[0];
        fork
            i_nfta_seq_model.run(3'h5, n);
            begin
                repeat (3) @(posedge clk);
                bus(1'b1, ofs[0], ~d, 4'hf);
                repeat (2) @(posedge clk);
                chk(out[0], d);
            end
        join
        chk(n, 32'h3f);
        cur[0] = mrg(d, ~d, 4'hf, msk[0]);
        repeat (2) @(posedge clk);
        chk(out[0], cur[0]);
        end_sim;
    end
endmodule // nfta_config_tb_top
bind nfta_config nfta_config_checker i_nfta_config_checker (.clk, .sys_rst, .wb_cyc_i,
    .wb_stb_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .cmd_active, .phase_start, .phase_busy,
    .phase_done, .valid_page_count, .busy_wait_cycles);
`default_nettype wire
